// [hdl/uswf_ctrl.sv]
// Suspend, wake, flush and reset control for both channels
//
// Operation
// - Power enable low once enumerated
// - Power enable high during USB suspend
// - Pull IO low when option set, power off
// - Wake strobe in suspend requests resume
// - Wake strobe normally flushes data next IN
// - Flush timeout held, 1 to 255 ms
// - External reset input resets the logic
// - Reset output derived from power-on reset
// - Enumeration waits for stable clocks
// - Configuration bit selects isochronous transfers
// - Each channel has its own wake input
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module uswf_ctrl
  import uswf_pkg::*;
#(
  parameter int unsigned MS_COUNT = MS_CYCLES
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire logic              por_done,
  // USB engine state
  input  wire logic              usb_configured,
  input  wire logic              usb_suspended,
  input  wire logic              clock_settle_check,
  input  wire logic [1:0]        rx_data_waiting,
  input  wire logic [1:0]        bulk_in_taken,
  output logic                   enum_allow,
  output logic                   resume_req,
  output uswf_chan_req_type      chan_req_a,
  output uswf_chan_req_type      chan_req_b,
  // Pins
  input  wire logic [1:0]        send_now_wake_n,
  output logic                   power_switch_en_n,
  output logic                   io_pulldown,
  output logic                   reset_out_n,
  // Register port
  input  wire logic [3:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [7:0]             reg_rdata,
  output logic                   irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  // Filtered pins, edge events and timer results
  logic [1:0]          wake_lvl;
  logic [1:0]          wake_prev_reg;
  logic [1:0]          wake_fall;
  logic [1:0]          tmo_exp;

  // Millisecond prescaler
  logic                tick;
  logic [MS_CNT_W-1:0] ms_cnt_reg;
  logic [MS_CNT_W-1:0] ms_cnt_next;

  // Register file and interrupt
  logic [7:0]          ctrl_reg;
  logic [7:0]          ctrl_next;
  logic [7:0]          flush_reg [2];
  logic [7:0]          flush_next [2];
  logic [IRQ_W-1:0]    istat_reg;
  logic [IRQ_W-1:0]    istat_next;
  logic [IRQ_W-1:0]    imask_reg;
  logic [IRQ_W-1:0]    imask_next;
  logic [7:0]          rdata_reg;
  logic [7:0]          rdata_next;
  logic                irq_reg;
  logic                irq_next;

  // Power switch, pull-down and enumeration gate
  logic                pwr_n_reg;
  logic                pwr_n_next;
  logic                pull_reg;
  logic                pull_next;
  logic                enum_reg;
  logic                enum_next;
  logic                settle_lvl;

  // Wake and flush requests
  logic                resume_reg;
  logic                resume_next;
  logic [1:0]          send_reg;
  logic [1:0]          send_next;
  logic [1:0]          short_reg;
  logic [1:0]          short_next;
  logic [1:0]          flush_pend_reg;
  logic [1:0]          flush_pend_next;

  // Reset output stretch
  logic [7:0]          rst_cnt_reg;
  logic [7:0]          rst_cnt_next;
  logic                rst_out_reg;
  logic                rst_out_next;

  // Clamp a written timeout into the legal range; zero would expire on every tick
  function automatic logic [7:0] clamp_ms(input logic [7:0] v);
    clamp_ms = (v < FLUSH_MS_MIN) ? FLUSH_MS_MIN : v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and per-channel timers

  // Settle level starts low: enumeration stays held off until the pin is seen high
  uswf_sync #(.RST_VAL(1'b0)) u_sync_settle (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .pin_in    (clock_settle_check),
    .level_out (settle_lvl)
  );

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    uswf_sync #(.RST_VAL(1'b1)) u_sync_wake (
      .core_clk  (core_clk),
      .rst_b     (rst_b),
      .pin_in    (send_now_wake_n[ch]),
      .level_out (wake_lvl[ch])
    );

    uswf_flush_tmr u_tmr (
      .core_clk     (core_clk),
      .rst_b        (rst_b),
      .ms_tick      (tick),
      .timeout_ms   (flush_reg[ch]),
      .data_waiting (rx_data_waiting[ch]),
      .restart      (bulk_in_taken[ch]),
      .expired      (tmo_exp[ch])
    );
  end

  // Falling edge of each filtered wake input, channels kept apart
  assign wake_fall = wake_prev_reg & ~wake_lvl;

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick
  // One prescaler serves both channel timers, so their ticks stay aligned

  always_comb begin
    tick        = (ms_cnt_reg == MS_CNT_W'(MS_COUNT - 1));
    ms_cnt_next = tick ? '0 : ms_cnt_reg + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power, enumeration gate and reset output

  always_comb begin
    enum_next    = settle_lvl;
    // Switch drops in suspend even while still configured
    pwr_n_next   = !(usb_configured && !usb_suspended);
    pull_next    = ctrl_reg[CTRL_PULLDN] && pwr_n_reg;
    rst_cnt_next = rst_cnt_reg;
    rst_out_next = rst_out_reg;
    // Stretch the release so external parts see a clean reset edge
    // The external reset input restarts the stretch as well
    if (!por_done) begin
      rst_cnt_next = 8'h00;
      rst_out_next = 1'b0;
    end else if (rst_cnt_reg != RESET_OUT_N_CYCLES) begin
      rst_cnt_next = rst_cnt_reg + 8'h01;
    end else begin
      rst_out_next = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake and flush requests

  always_comb begin
    resume_next     = 1'b0;
    send_next       = 2'b00;
    short_next      = 2'b00;
    flush_pend_next = flush_pend_reg;
    for (int c = 0; c < 2; c++) begin
      // A strobe in suspend without remote wake only sets its status bit
      if (wake_fall[c] && usb_suspended && ctrl_reg[CTRL_RWAKE]) begin
        resume_next = 1'b1;
      end else if (wake_fall[c] && !usb_suspended) begin
        flush_pend_next[c] = 1'b1;
      end
      // Pending flush holds until the next IN takes it; an empty buffer drops it,
      // so a strobe never flushes data that arrives long afterwards
      if (bulk_in_taken[c] || !rx_data_waiting[c]) begin
        flush_pend_next[c] = 1'b0;
      end
      send_next[c]  = flush_pend_reg[c] && rx_data_waiting[c];
      short_next[c] = tmo_exp[c];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file and interrupt

  always_comb begin
    ctrl_next  = ctrl_reg;
    flush_next = flush_reg;
    imask_next = imask_reg;
    istat_next = istat_reg;
    rdata_next = 8'h00;
    // Unmapped addresses ignore writes and read as zero
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_CTRL:     ctrl_next     = reg_wdata;
        OFS_FLUSH_A:  flush_next[0] = clamp_ms(reg_wdata);
        OFS_FLUSH_B:  flush_next[1] = clamp_ms(reg_wdata);
        OFS_IRQ_STAT: istat_next    = istat_reg & ~reg_wdata[IRQ_W-1:0];
        OFS_IRQ_MASK: imask_next    = reg_wdata[IRQ_W-1:0];
        default:      ;
      endcase
    end
    // Events set after the clear so a same-cycle event is kept
    istat_next[IRQ_WAKE_A] = istat_next[IRQ_WAKE_A] | (wake_fall[0] & usb_suspended);
    istat_next[IRQ_WAKE_B] = istat_next[IRQ_WAKE_B] | (wake_fall[1] & usb_suspended);
    istat_next[IRQ_SEND_A] = istat_next[IRQ_SEND_A] | (wake_fall[0] & ~usb_suspended);
    istat_next[IRQ_SEND_B] = istat_next[IRQ_SEND_B] | (wake_fall[1] & ~usb_suspended);
    istat_next[IRQ_TMO_A]  = istat_next[IRQ_TMO_A] | tmo_exp[0];
    istat_next[IRQ_TMO_B]  = istat_next[IRQ_TMO_B] | tmo_exp[1];
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_CTRL:     rdata_next = ctrl_reg;
        OFS_STATUS:   rdata_next = {2'b00, flush_pend_reg, usb_suspended,
                                    usb_configured, enum_reg, pwr_n_reg};
        OFS_FLUSH_A:  rdata_next = flush_reg[0];
        OFS_FLUSH_B:  rdata_next = flush_reg[1];
        OFS_IRQ_STAT: rdata_next = {2'b00, istat_reg};
        OFS_IRQ_MASK: rdata_next = {2'b00, imask_reg};
        default:      rdata_next = 8'h00;
      endcase
    end
    irq_next = |(istat_next & imask_next);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers; external reset input arrives through rst_b
  // Every register resets to its idle level, so no false event follows reset

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ms_cnt_reg     <= '0;
      wake_prev_reg  <= 2'b11;
      ctrl_reg       <= CTRL_RST;
      flush_reg[0]   <= FLUSH_MS_RST;
      flush_reg[1]   <= FLUSH_MS_RST;
      istat_reg      <= '0;
      imask_reg      <= '0;
      rdata_reg      <= 8'h00;
      irq_reg        <= 1'b0;
      pwr_n_reg      <= 1'b1;
      pull_reg       <= 1'b0;
      enum_reg       <= 1'b0;
      resume_reg     <= 1'b0;
      send_reg       <= 2'b00;
      short_reg      <= 2'b00;
      flush_pend_reg <= 2'b00;
      rst_cnt_reg    <= 8'h00;
      rst_out_reg    <= 1'b0;
    end else begin
      ms_cnt_reg     <= ms_cnt_next;
      wake_prev_reg  <= wake_lvl;
      ctrl_reg       <= ctrl_next;
      flush_reg      <= flush_next;
      istat_reg      <= istat_next;
      imask_reg      <= imask_next;
      rdata_reg      <= rdata_next;
      irq_reg        <= irq_next;
      pwr_n_reg      <= pwr_n_next;
      pull_reg       <= pull_next;
      enum_reg       <= enum_next;
      resume_reg     <= resume_next;
      send_reg       <= send_next;
      short_reg      <= short_next;
      flush_pend_reg <= flush_pend_next;
      rst_cnt_reg    <= rst_cnt_next;
      rst_out_reg    <= rst_out_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops

  assign power_switch_en_n    = pwr_n_reg;
  assign io_pulldown          = pull_reg;
  assign enum_allow           = enum_reg;
  assign resume_req           = resume_reg;
  assign reset_out_n          = rst_out_reg;
  assign reg_rdata            = rdata_reg;
  assign irq                  = irq_reg;
  // Request bundles towards the USB engine; iso mode follows its option bit
  // directly, so a mode change reaches the engine with no extra lag
  assign chan_req_a.send_now  = send_reg[0];
  assign chan_req_a.short_pkt = short_reg[0];
  assign chan_req_a.iso_mode  = ctrl_reg[CTRL_ISO_A];
  assign chan_req_b.send_now  = send_reg[1];
  assign chan_req_b.short_pkt = short_reg[1];
  assign chan_req_b.iso_mode  = ctrl_reg[CTRL_ISO_B];

endmodule
`default_nettype wire

// [hdl/uswf_pkg.sv]
// Package: constants and carrier types of the suspend, wake and flush controller
package uswf_pkg;

  // Timing: one millisecond tick at the core clock rate
  localparam int unsigned CLK_HZ         = 25000000;
  localparam int unsigned TICK_MS        = 1;
  localparam int unsigned MS_CYCLES      = (CLK_HZ / 1000) * TICK_MS;
  localparam int unsigned MS_CNT_W       = 15;

  // Flush timeout range in milliseconds
  localparam logic [7:0]  FLUSH_MS_MIN   = 8'h01;
  localparam logic [7:0]  FLUSH_MS_MAX   = 8'hFF;
  localparam logic [7:0]  FLUSH_MS_RST   = 8'h10;

  // Register offsets
  localparam logic [3:0]  OFS_CTRL       = 4'h0;
  localparam logic [3:0]  OFS_STATUS     = 4'h1;
  localparam logic [3:0]  OFS_FLUSH_A    = 4'h2;
  localparam logic [3:0]  OFS_FLUSH_B    = 4'h3;
  localparam logic [3:0]  OFS_IRQ_STAT   = 4'h4;
  localparam logic [3:0]  OFS_IRQ_MASK   = 4'h5;

  // Control register field positions
  localparam int unsigned CTRL_PULLDN    = 0;
  localparam int unsigned CTRL_RWAKE     = 1;
  localparam int unsigned CTRL_ISO_A     = 2;
  localparam int unsigned CTRL_ISO_B     = 3;
  localparam logic [7:0]  CTRL_RST       = 8'h00;

  // Interrupt status bit positions
  localparam int unsigned IRQ_WAKE_A     = 0;
  localparam int unsigned IRQ_WAKE_B     = 1;
  localparam int unsigned IRQ_SEND_A     = 2;
  localparam int unsigned IRQ_SEND_B     = 3;
  localparam int unsigned IRQ_TMO_A      = 4;
  localparam int unsigned IRQ_TMO_B      = 5;
  localparam int unsigned IRQ_W          = 6;

  // Reset output stretch in core cycles
  localparam logic [7:0]  RESET_OUT_N_CYCLES  = 8'h20;

  // Per-channel link request towards the USB engine
  typedef struct packed {
    logic send_now;   // Level: held until next IN takes the pending data
    logic short_pkt;  // Pulse: timeout flush on next IN
    logic iso_mode;   // Level: isochronous instead of bulk
  } uswf_chan_req_type;

endpackage

// [hdl/uswf_sync.sv]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module uswf_sync #(
  parameter logic RST_VAL = 1'b1
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_b,
  // Data
  input  wire logic pin_in,
  output logic      level_out
);

  logic [2:0] stage_reg;
  logic [2:0] stage_next;
  logic       level_reg;
  logic       level_next;

  // Shift and accept a change only when the last two stages agree
  always_comb begin
    stage_next = {stage_reg[1:0], pin_in};
    level_next = (stage_reg[2] == stage_reg[1]) ? stage_reg[1] : level_reg;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage_reg <= {3{RST_VAL}};
      level_reg <= RST_VAL;
    end else begin
      stage_reg <= stage_next;
      level_reg <= level_next;
    end
  end

  assign level_out = level_reg;

endmodule
`default_nettype wire

// [hdl/uswf_flush_tmr.sv]
// Per-channel receive-buffer flush timer counting millisecond ticks
`timescale 1ns/100ps
`default_nettype none
module uswf_flush_tmr
  import uswf_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // Control
  input  wire logic       ms_tick,
  input  wire logic [7:0] timeout_ms,
  input  wire logic       data_waiting,
  input  wire logic       restart,
  // Result
  output logic            expired
);

  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic       exp_reg;
  logic       exp_next;

  // Count while data waits; fire once then rearm, so a stuck buffer flushes periodically
  always_comb begin
    count_next = count_reg;
    exp_next   = 1'b0;
    if (!data_waiting || restart) begin
      count_next = 8'h00;
    end else if (ms_tick) begin
      if (count_reg + 8'h01 >= timeout_ms) begin
        count_next = 8'h00;
        exp_next   = 1'b1;
      end else begin
        count_next = count_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= 8'h00;
      exp_reg   <= 1'b0;
    end else begin
      count_reg <= count_next;
      exp_reg   <= exp_next;
    end
  end

  assign expired = exp_reg;

endmodule
`default_nettype wire

// [verification/uswf_usb_model.sv]
// USB engine model: receive buffer flag per channel and IN polling
`timescale 1ns/100ps
`default_nettype none
module uswf_usb_model
  import uswf_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  // Bench stimulus
  input  wire logic [1:0]        fill,
  input  wire logic              slow,
  // Flush requests
  input  wire uswf_chan_req_type chan_req_a,
  input  wire uswf_chan_req_type chan_req_b,
  // Buffer state and IN service
  output logic [1:0]             rx_data_waiting,
  output logic [1:0]             bulk_in_taken
);
  logic [1:0] go;
  int         wt [2];

  // A request matters only while data waits
  assign go = {chan_req_b.send_now | chan_req_b.short_pkt,
               chan_req_a.send_now | chan_req_a.short_pkt};

  // Host polls IN after one or six cycles; a served IN empties the buffer
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_data_waiting <= 2'h0;
      bulk_in_taken   <= 2'h0;
      wt              <= '{0, 0};
    end else begin
      for (int i = 0; i < 2; i++) begin
        bulk_in_taken[i] <= 1'b0;
        if (fill[i]) begin
          rx_data_waiting[i] <= 1'b1;
        end else if (rx_data_waiting[i] && (go[i] || wt[i] > 0)) begin
          if (wt[i] >= (slow ? 6 : 1)) begin
            bulk_in_taken[i]   <= 1'b1;
            rx_data_waiting[i] <= 1'b0;
            wt[i]              <= 0;
          end else begin
            wt[i] <= wt[i] + 1;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// [verification/uswf_ctrl_assertions.sv]
// Port checks of the suspend, wake and flush controller
`timescale 1ns/100ps
`default_nettype none
module uswf_ctrl_assertions
  import uswf_pkg::*;
(
  // Clock, reset, USB state
  input wire logic       core_clk,
  input wire logic       rst_b,
  input wire logic       por_done,
  input wire logic       usb_configured,
  input wire logic       usb_suspended,
  input wire logic       clock_settle_check,
  input wire logic [1:0] rx_data_waiting,
  input wire logic       enum_allow,
  input wire logic       resume_req,
  // Pins
  input wire logic [1:0] send_now_wake_n,
  input wire logic       power_switch_en_n,
  input wire logic       io_pulldown,
  input wire logic       reset_out_n,
  // Register writes
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  // Channel requests
  input wire uswf_chan_req_type chan_req_a,
  input wire uswf_chan_req_type chan_req_b
);
  logic [3:0] opt_reg;
  logic [3:0] opt_next;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // Mirror of the option bits, so checks need no internal probes
  always_comb begin
    opt_next = (reg_wr && reg_addr == OFS_CTRL) ? reg_wdata[3:0] : opt_reg;
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      opt_reg <= 4'h0;
    end else begin
      opt_reg <= opt_next;
    end
  end

  pwr_on_a: assert property (usb_configured && !usb_suspended |=> !power_switch_en_n)
    else $error("power enable not active");
  pwr_off_a: assert property (usb_suspended |=> power_switch_en_n)
    else $error("power enable active in suspend");
  pull_down_a: assert property (rst_b |=>
    io_pulldown == $past(opt_reg[CTRL_PULLDN] && power_switch_en_n))
    else $error("pull-down level wrong");
  wake_resume_a: assert property ($fell(send_now_wake_n[0]) && usb_suspended
    && opt_reg[CTRL_RWAKE] ##1 (!send_now_wake_n[0] && usb_suspended)[*3] |-> ##[1:6] resume_req)
    else $error("no resume after wake strobe");
  resume_gate_a: assert property (resume_req |-> $past(opt_reg[CTRL_RWAKE]) && $past(usb_suspended))
    else $error("resume without remote wake");
  send_flush_a: assert property ($fell(send_now_wake_n[0]) && !usb_suspended && rx_data_waiting[0]
    ##1 (!send_now_wake_n[0] && !usb_suspended)[*3] |-> ##[1:6] chan_req_a.send_now)
    else $error("no flush after send strobe");
  iso_sel_a: assert property ($stable(opt_reg) && $past(rst_b) |->
    chan_req_a.iso_mode == opt_reg[CTRL_ISO_A] && chan_req_b.iso_mode == opt_reg[CTRL_ISO_B])
    else $error("iso mode wrong");
  reset_out_n_len_a: assert property ($rose(por_done) |-> (!reset_out_n)[*8] ##25 !reset_out_n ##1 reset_out_n)
    else $error("reset output stretch wrong");
  enum_gate_a: assert property ($fell(clock_settle_check) ##1 (!clock_settle_check)[*6]
    |-> !enum_allow)
    else $error("enumeration not held off");
  short_pkt_a: assert property (chan_req_a.short_pkt |-> $past(rx_data_waiting[0])
    ##1 !chan_req_a.short_pkt)
    else $error("short packet pulse wrong");
endmodule
bind uswf_ctrl uswf_ctrl_assertions i_chk (.*);
`default_nettype wire

// [verification/uswf_ctrl_tb.sv]
// Self-checking bench of the suspend, wake and flush controller
`timescale 1ns/100ps
`default_nettype none
module uswf_ctrl_tb
  import uswf_pkg::*;
;
  localparam int MSC = 10;
  // Design and model signals
  logic              core_clk, rst_b, por_done, usb_configured, usb_suspended;
  logic              clock_settle_check, enum_allow, resume_req, io_pulldown, irq;
  logic              power_switch_en_n, reset_out_n, reg_wr, reg_rd, slow;
  logic [1:0]        rx_data_waiting, bulk_in_taken, send_now_wake_n, fill;
  logic [3:0]        reg_addr;
  logic [7:0]        reg_wdata, reg_rdata, got;
  uswf_chan_req_type chan_req_a, chan_req_b;
  int                fails, n_tests, n_res, n_sp, seed, v;
  int                n_srv [2];
  int                mdl [16];

  uswf_ctrl #(.MS_COUNT(MSC)) i_dut (.*);
  uswf_usb_model i_usb (.*);

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Count one-cycle events mid-cycle, where they are settled
  always @(negedge core_clk) begin
    if (resume_req === 1'b1) n_res++;
    if (chan_req_a.short_pkt === 1'b1) n_sp++;
    if (chan_req_b.short_pkt === 1'b1) n_sp++;
    for (int i = 0; i < 2; i++) if (bulk_in_taken[i] === 1'b1) n_srv[i]++;
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic look(input int n);
    cyc(n);
    @(negedge core_clk);
  endtask
  // Register reset values of the mirror
  task automatic mreset;
    foreach (mdl[i]) mdl[i] = 0;
    mdl[2] = int'(FLUSH_MS_RST);
    mdl[3] = int'(FLUSH_MS_RST);
  endtask
  // Every driver starts on an edge, so strobes never clash
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    case (a)
      OFS_IRQ_STAT: mdl[4] = mdl[4] & ~int'(d);
      OFS_FLUSH_A, OFS_FLUSH_B: mdl[a] = (d == 8'h00) ? 1 : int'(d);
      OFS_CTRL, OFS_IRQ_MASK: mdl[a] = int'(d);
      default: ;
    endcase
  endtask
  task automatic rc(input logic [3:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 got = reg_rdata;
    chk(got, 8'(mdl[a]));
  endtask
  task automatic strobe(input int c);
    @(posedge core_clk);
    send_now_wake_n[c] <= 1'b0;
    cyc(4);
    send_now_wake_n[c] <= 1'b1;
    cyc(10);
  endtask
  task automatic load(input int c);
    @(posedge core_clk);
    fill[c] <= 1'b1;
    @(posedge core_clk);
    fill[c] <= 1'b0;
  endtask
  task automatic wrap_up;
    $display("TB: %0d compares, %0d mismatches", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run of a few hundred cycles
  initial begin
    cyc(20000);
    fails++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up;
  end

  initial begin
    seed = 32'h55B5;
    {rst_b, por_done, usb_configured, usb_suspended, clock_settle_check} = 5'h00;
    {reg_wr, reg_rd, slow, fill, reg_addr, reg_wdata} = 17'h00000;
    send_now_wake_n = 2'h3;
    mreset;
    cyc(3);
    rst_b <= 1'b1;
    // Reset output stretch and clock settle gate, from the first edge on
    look(1);
    chk(8'({reset_out_n, enum_allow}), 8'h00);
    look(9);
    chk(8'({reset_out_n, enum_allow}), 8'h00);
    cyc(1);
    por_done           <= 1'b1;
    clock_settle_check <= 1'b1;
    look(20);
    chk(8'(reset_out_n), 8'h00);
    look(20);
    chk(8'({reset_out_n, enum_allow}), 8'h03);
    cyc(1);
    clock_settle_check <= 1'b0;
    look(10);
    chk(8'(enum_allow), 8'h00);
    cyc(1);
    clock_settle_check <= 1'b1;
    $display("TB: test settle done");
    // Register reset values, unmapped places read as zero
    for (int a = 0; a < 16; a++) if (a != 1) rc(4'(a));
    // Flush timeout range with zero, ends and a random value
    for (int i = 0; i < 4; i++) begin
      v = (i == 3) ? 2 + $unsigned($random(seed)) % 253 : (i == 2) ? 255 : i;
      wr(OFS_FLUSH_B, 8'(v));
      rc(OFS_FLUSH_B);
    end
    $display("TB: test registers done");
    // Power switch and pull-down
    cyc(1);
    usb_configured <= 1'b1;
    look(3);
    chk(8'({power_switch_en_n, io_pulldown}), 8'h00);
    wr(OFS_CTRL, 8'h03);
    cyc(1);
    usb_suspended <= 1'b1;
    look(3);
    chk(8'({power_switch_en_n, io_pulldown}), 8'h03);
    $display("TB: test power done");
    // Wake in suspend, masked and unmasked, with and without remote wake
    wr(OFS_IRQ_MASK, 8'h01);
    strobe(0);
    look(1);
    chk(8'({n_res[6:0], irq}), 8'h03);
    mdl[4] = mdl[4] | (1 << IRQ_WAKE_A);
    rc(OFS_IRQ_STAT);
    wr(OFS_IRQ_STAT, 8'h01);
    wr(OFS_CTRL, 8'h01);
    strobe(1);
    look(1);
    chk(8'({n_res[6:0], irq}), 8'h02);
    mdl[4] = mdl[4] | (1 << IRQ_WAKE_B);
    rc(OFS_IRQ_STAT);
    $display("TB: test wake done");
    // Send-now per channel with a slow host
    cyc(1);
    usb_suspended <= 1'b0;
    slow          <= 1'b1;
    wr(OFS_FLUSH_A, 8'hFF);
    load(0);
    strobe(1);
    look(1);
    chk(8'({n_srv[0][3:0], io_pulldown}), 8'h00);
    // Strobe on an empty channel leaves no flush pending
    mdl[1] = 32'h6;
    rc(OFS_STATUS);
    strobe(0);
    look(10);
    chk(8'(n_srv[0]), 8'h01);
    mdl[4] = mdl[4] | (1 << IRQ_SEND_A) | (1 << IRQ_SEND_B);
    rc(OFS_IRQ_STAT);
    // Timeout flush on both channels with a short random count
    v = 1 + $unsigned($random(seed)) % 3;
    wr(OFS_FLUSH_A, 8'(v));
    wr(OFS_FLUSH_B, 8'(v));
    cyc(1);
    slow <= 1'b0;
    load(0);
    load(1);
    look(v * MSC + 30);
    chk(8'({n_sp[3:0], n_srv[0][3:0]}), 8'h22);
    chk(8'(n_srv[1]), 8'h01);
    mdl[4] = mdl[4] | (1 << IRQ_TMO_A) | (1 << IRQ_TMO_B);
    rc(OFS_IRQ_STAT);
    $display("TB: test flush done");
    // Transfer type per channel
    for (int i = 0; i < 2; i++) begin
      wr(OFS_CTRL, 8'h04 << i);
      look(3);
      chk(8'({chan_req_a.iso_mode, chan_req_b.iso_mode}), 8'h02 >> i);
    end
    // Reset in mid-run
    cyc(1);
    rst_b <= 1'b0;
    cyc(2);
    rst_b <= 1'b1;
    mreset;
    look(1);
    chk(8'({reset_out_n, enum_allow}), 8'h00);
    for (int a = 0; a < 6; a++) if (a != 1) rc(4'(a));
    $display("TB: test reset done");
    wrap_up;
  end
endmodule
`default_nettype wire
